// file: common/pao_pkg.sv
package pao_pkg;
  localparam int STAGE_COUNT = 8;
  localparam int STAGE_BITS = 2;
  localparam int RAW_BITS = 18;
  localparam int SAMPLE_BITS = 10;
  localparam int PIPELINE_LATENCY = 7;
  localparam int SETTLE_CYCLES = 20;
  localparam int MSB_POS = 9;
  localparam logic [9:0] RESET_WORD = 10'h000;
endpackage

// file: design/pao_delay_line.sv
`timescale 1ns/10ps
module pao_delay_line #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] taps [DEPTH];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        taps[i] <= '0;
      end
    end else begin
      taps[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        taps[i] <= taps[i-1];
      end
    end
  end

  assign dout = taps[DEPTH-1];
endmodule // pao_delay_line

// file: design/pao_output_logic.sv
`timescale 1ns/10ps
module pao_output_logic (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [pao_pkg::STAGE_COUNT*pao_pkg::STAGE_BITS-1:0] stage_codes,
  input wire logic [pao_pkg::STAGE_BITS-1:0] flash_code,
  input wire logic code_format_select,
  input wire logic output_enable_n,
  output logic [pao_pkg::SAMPLE_BITS-1:0] data_out,
  output logic [pao_pkg::SAMPLE_BITS-1:0] data_oe,
  output logic sample_phase,
  output logic amplify_phase,
  output logic sample_strobe,
  output logic data_valid
);
  localparam int NS = pao_pkg::STAGE_COUNT;
  localparam int SB = pao_pkg::STAGE_BITS;
  localparam int W = pao_pkg::SAMPLE_BITS;
  // Stages 0..7 each need 8-k cycles; flash needs one; then correction and two latches
  localparam int FILL = pao_pkg::PIPELINE_LATENCY;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SB*NS+SB+1:0] pin_meta;
  logic [SB*NS+SB+1:0] pin_sync;
  always_ff @(posedge mclk) begin
    pin_meta <= {stage_codes, flash_code, code_format_select, output_enable_n};
    pin_sync <= pin_meta;
  end
  wire [SB*NS-1:0] st_s = pin_sync[SB*NS+SB+1:SB+2];
  wire [SB-1:0] fl_s = pin_sync[SB+1:2];
  wire fmt_s = pin_sync[1];
  wire oe_n_s = pin_sync[0];

  ////////////////////////////////////////////////////////////////
  // Two-phase clock and sample command
  logic phase;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase <= 1'b0;
      sample_phase <= 1'b0;
      amplify_phase <= 1'b0;
      sample_strobe <= 1'b0;
    end else begin
      phase <= ~phase;
      sample_phase <= ~phase;
      amplify_phase <= phase;
      // Sample taken at end of acquire phase, the falling half of the clock
      sample_strobe <= phase;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Alignment delay line
  logic [pao_pkg::RAW_BITS-1:0] raw_word;
  for (genvar k = 0; k < NS; k++) begin : g_stage
    pao_delay_line #(.WIDTH(SB), .DEPTH(NS - k)) u_dly (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .din(st_s[SB*k +: SB]),
      .dout(raw_word[pao_pkg::RAW_BITS-1-SB*k -: SB])
    );
  end
  pao_delay_line #(.WIDTH(SB), .DEPTH(1)) u_flash (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din(fl_s),
    .dout(raw_word[SB-1:0])
  );

  ////////////////////////////////////////////////////////////////
  // Error correction: overlapping add of the two-bit digits
  function automatic logic [W-1:0] pao_correct(input logic [pao_pkg::RAW_BITS-1:0] raw);
    logic [W:0] acc;
    acc = '0;
    for (int i = 0; i <= NS; i++) begin
      acc = (W+1)'(acc + ((W+1)'(raw[SB*i +: SB]) << i));
    end
    // Overflow clamps to full scale instead of wrapping
    return acc[W] ? {W{1'b1}} : acc[W-1:0];
  endfunction

  wire [W-1:0] corrected = pao_correct(raw_word);
  wire [W-1:0] formatted = fmt_s ? {~corrected[pao_pkg::MSB_POS], corrected[W-2:0]} : corrected;

  ////////////////////////////////////////////////////////////////
  // Double-buffered output latches
  logic [W-1:0] latch_a;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      latch_a <= pao_pkg::RESET_WORD;
      data_out <= pao_pkg::RESET_WORD;
      data_oe <= '0;
    end else begin
      latch_a <= formatted;
      data_out <= latch_a;
      data_oe <= {W{~oe_n_s}};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Settling count and pipeline fill
  logic [4:0] settle_cnt;
  logic [2:0] fill_cnt;
  wire settled = (settle_cnt == 5'(pao_pkg::SETTLE_CYCLES));
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      settle_cnt <= '0;
      fill_cnt <= '0;
      data_valid <= 1'b0;
    end else begin
      if (!settled) begin
        settle_cnt <= settle_cnt + 5'h01;
      end
      if (settled && fill_cnt != 3'(FILL)) begin
        fill_cnt <= fill_cnt + 3'h1;
      end
      data_valid <= settled && (fill_cnt == 3'(FILL));
    end
  end
endmodule // pao_output_logic

// file: bench/pao_output_logic_asserts.sv
`timescale 1ns/10ps
module pao_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic output_enable_n,
  input wire logic [9:0] data_oe,
  input wire logic sample_phase,
  input wire logic amplify_phase,
  input wire logic sample_strobe,
  input wire logic data_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [5:0] cnt;
  always_ff @(posedge mclk) cnt <= sys_rst ? 6'h00 : cnt + {5'h00, ~&cnt};
  sequence s_oe(v); (output_enable_n == v) [*4]; endsequence
  chk_phase_pair: assert property (!$past(sys_rst, 2) |-> sample_phase ^ amplify_phase) else $error("phase");
  chk_phase_swap: assert property (!$past(sys_rst, 2) |=> $changed(sample_phase)) else $error("swap");
  // Skip the first edge after reset, where the enable still shows its reset value
  chk_oe_drive: assert property (cnt != 6'h00 && s_oe(1'b0) |-> data_oe == 10'h3FF) else $error("drive");
  chk_strobe_end: assert property (!$past(sys_rst, 2) |-> sample_strobe == $past(sample_phase)) else $error("strobe");
  chk_oe_release: assert property (s_oe(1'b1) |-> data_oe == 10'h000) else $error("release");
  chk_valid_hold: assert property (data_valid |=> data_valid) else $error("hold");
  chk_valid_late: assert property (data_valid |-> cnt >= 6'h1B) else $error("early");
  chk_valid_due: assert property (cnt == 6'h28 |-> data_valid) else $error("late");
  chk_valid_clear: assert property ($fell(sys_rst) |-> !data_valid) else $error("clear");
endmodule // pao_chk

// file: bench/pao_capture.sv
`timescale 1ns/10ps
module pao_capture (
  input wire logic mclk,
  input wire logic [9:0] data_out,
  input wire logic [9:0] data_oe,
  input wire logic data_valid,
  output logic [9:0] word
);
  always_ff @(posedge mclk) if (data_valid) word <= (data_out & data_oe) | (~word & ~data_oe);
endmodule // pao_capture

// file: bench/tb_pao_output_logic.sv
`timescale 1ns/10ps
module tb_pao_output_logic;
  logic mclk = 1'b0, sys_rst = 1'b1, code_format_select = 1'b0, output_enable_n = 1'b0;
  logic [15:0] stage_codes = 16'h0000;
  logic [1:0] flash_code = 2'h0;
  logic [9:0] data_out, data_oe, word;
  logic sample_phase, amplify_phase, sample_strobe, data_valid;
  int err_count = 0, n_checks = 0, cyc = 0;
  pao_output_logic pao_output_logic_inst (.*);
  pao_capture pao_capture_inst (.*);
  always #25 mclk = ~mclk;
  always @(posedge mclk) if (++cyc > 1500) wrap_up();
  task check(input logic [9:0] s, e);
    n_checks++;
    err_count += (s !== e);
    if (s !== e) $display("wrong value %0t %h %h", $time, s, e);
  endtask
  task wrap_up;
    err_count += (cyc > 1500);
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task t_word(input logic [18:0] v, input logic [9:0] e);
    @(posedge mclk);
    {stage_codes, flash_code, code_format_select} <= v;
    repeat (16) @(posedge mclk);
    #1 check(word, e);
  endtask
  task t_oe(input logic n);
    @(posedge mclk);
    output_enable_n <= n;
    repeat (5) @(posedge mclk);
    #1 check(data_oe, {10{!n}});
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (40) @(posedge mclk);
    t_word({16'h0000, 2'h0, 1'b1}, 10'h200);
    t_word({16'h5555, 2'h1, 1'b0}, 10'h1FF);
    t_word({16'hFFFF, 2'h3, 1'b1}, 10'h1FF);
    t_oe(1'b1);
    t_oe(1'b0);
    wrap_up();
  end
endmodule // tb_pao_output_logic
bind pao_output_logic pao_chk pao_chk_inst (.*);
